// ==== hdl/bch_pkg.sv ====
// Summary of operation
// - Self-test byte always reads zero
// - Both base address registers read zero
// - Upstream bus number: 8-bit RW, reset zero
// - Upstream bus number never affects behaviour
// - Downstream bus number: 8-bit RW, reset zero
// - Highest bus number: 8-bit RW, reset zero
// - Downstream latency timer always reads zero
// - Width capability bit: lockable write, resets one
// - Window high bit 0 mirrors capability
// - Window low bits 7:4 RW, reset ones
// - Window high bits 7:4 RW, reset zero
// - Window settings decide I/O forwarding
package bch_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_SELF_TEST  = 6'h0f;
	localparam logic [5:0] IDX_BASE_ZERO  = 6'h10;
	localparam logic [5:0] IDX_BASE_ONE   = 6'h14;
	localparam logic [5:0] IDX_UP_BUS     = 6'h18;
	localparam logic [5:0] IDX_DN_BUS     = 6'h19;
	localparam logic [5:0] IDX_HI_BUS     = 6'h1a;
	localparam logic [5:0] IDX_LAT_TIMER  = 6'h1b;
	localparam logic [5:0] IDX_WIN_LOW    = 6'h1c;
	localparam logic [5:0] IDX_WIN_HIGH   = 6'h1d;

	// Field positions of the window registers
	localparam int WIN_CAP_BIT = 0;
	localparam int WIN_ADR_LSB = 4;
	localparam int WIN_ADR_MSB = 7;

	// Reset values
	localparam logic [7:0] RST_BUS_NUM  = 8'h00;
	localparam logic [3:0] RST_WIN_LOW  = 4'hf;
	localparam logic [3:0] RST_WIN_HIGH = 4'h0;
	localparam logic       RST_CAP      = 1'b1;
	localparam logic [31:0] RO_ZERO     = 32'h0000_0000;

	// Low address bits implied by the window bounds
	localparam logic [11:0] WIN_LOW_FILL  = 12'h000;
	localparam logic [11:0] WIN_HIGH_FILL = 12'hfff;

endpackage : bch_pkg

// ==== hdl/bch_win_if.sv ====
`timescale 1ns/1ps
interface bch_win_if;
	logic [3:0]  base_hi;
	logic [3:0]  lim_hi;
	logic        cap;
	logic [31:0] addr;
	logic        hit;

	modport cfg (output base_hi, output lim_hi, output cap, output addr,
		input hit);
	modport cmp (input base_hi, input lim_hi, input cap, input addr,
		output hit);
endinterface : bch_win_if

// ==== hdl/bch_win_cmp.sv ====
`timescale 1ns/1ps
module bch_win_cmp
(
	bch_win_if.cmp win // Window bounds in, hit out
);
	import bch_pkg::*;

	logic [15:0] lo_bound;
	logic [15:0] hi_bound;

	// Upper address half has no bound register here, so it must be zero
	always_comb
	begin
		lo_bound = {win.base_hi, WIN_LOW_FILL};
		hi_bound = {win.lim_hi, WIN_HIGH_FILL};
		win.hit  = (win.addr[31:16] == 16'h0000) &&
			(win.addr[15:0] >= lo_bound) &&
			(win.addr[15:0] <= hi_bound);
	end
endmodule : bch_win_cmp

// ==== hdl/bch_regs.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module bch_regs
#(
	parameter int AW = 8 // APB address width
)
(
	input  wire  logic          clk,         // 50 MHz clock
	input  wire  logic          resetn,      // Sync reset, active low
	input  wire  logic          psel,        // APB select
	input  wire  logic          penable,     // APB enable
	input  wire  logic          pwrite,      // APB direction
	input  wire  logic [AW-1:0] paddr,       // APB byte address
	input  wire  logic [31:0]   pwdata,      // APB write data
	input  wire  logic [3:0]    pstrb,       // APB byte strobes
	output logic                pready,      // APB ready
	output logic [31:0]         prdata,      // APB read data
	output logic                pslverr,     // APB error, unmapped
	input  wire  logic          cap_unlock,  // Opens capability write
	input  wire  logic          io_valid,    // I/O request present
	input  wire  logic [31:0]   io_addr,     // I/O request address
	output logic                io_forward   // Request is forwarded
);
	import bch_pkg::*;

	typedef struct packed {
		logic [7:0]  up_bus;
		logic [7:0]  dn_bus;
		logic [7:0]  hi_bus;
		logic [3:0]  base_hi;
		logic [3:0]  lim_hi;
		logic        cap;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        fwd;
	} bch_state_t;

	bch_state_t  st_ff;
	bch_state_t  nxt_st;
	logic        wr_done;
	logic [5:0]  acc_idx;

	bch_win_if win ();

	bch_win_cmp u_cmp
	(
		.win (win.cmp)
	);

	function automatic logic [5:0] reg_index(input logic [AW-1:0] a);
		reg_index = 6'(a >> 2);
	endfunction : reg_index

	function automatic logic is_mapped(input logic [AW-1:0] a);
		logic [5:0] i;
		i = reg_index(a);
		is_mapped = (a[1:0] == 2'b00) && (32'(a) < 32'h100) &&
			(i == IDX_SELF_TEST || i == IDX_BASE_ZERO ||
			i == IDX_BASE_ONE || i == IDX_UP_BUS || i == IDX_DN_BUS ||
			i == IDX_HI_BUS || i == IDX_LAT_TIMER ||
			i == IDX_WIN_LOW || i == IDX_WIN_HIGH);
	endfunction : is_mapped

	function automatic logic [31:0] read_value(input logic [5:0] i,
		input bch_state_t s);
		read_value = RO_ZERO;
		unique case (i)
			IDX_UP_BUS:   read_value = {24'h0, s.up_bus};
			IDX_DN_BUS:   read_value = {24'h0, s.dn_bus};
			IDX_HI_BUS:   read_value = {24'h0, s.hi_bus};
			IDX_WIN_LOW:  read_value = {24'h0, s.base_hi, 3'h0, s.cap};
			IDX_WIN_HIGH: read_value = {24'h0, s.lim_hi, 3'h0, s.cap};
			default:      read_value = RO_ZERO;
		endcase
	endfunction : read_value

	assign win.base_hi = st_ff.base_hi;
	assign win.lim_hi  = st_ff.lim_hi;
	assign win.cap     = st_ff.cap;
	assign win.addr    = io_addr;

	assign acc_idx = reg_index(paddr);
	assign wr_done = psel && penable && st_ff.pready && pwrite &&
		!st_ff.pslverr && pstrb[0];

	always_comb
	begin
		nxt_st = st_ff;
		// Answer in the first access cycle, no wait states
		nxt_st.pready  = psel && !penable;
		nxt_st.pslverr = psel && !penable && !is_mapped(paddr);
		if (psel && !penable)
		begin
			nxt_st.prdata = (pwrite || !is_mapped(paddr)) ? RO_ZERO :
				read_value(acc_idx, st_ff);
		end
		if (wr_done)
		begin
			unique case (acc_idx)
				IDX_UP_BUS: nxt_st.up_bus = pwdata[7:0];
				IDX_DN_BUS: nxt_st.dn_bus = pwdata[7:0];
				IDX_HI_BUS: nxt_st.hi_bus = pwdata[7:0];
				IDX_WIN_LOW:
				begin
					nxt_st.base_hi = pwdata[WIN_ADR_MSB:WIN_ADR_LSB];
					if (cap_unlock)
					begin
						nxt_st.cap = pwdata[WIN_CAP_BIT];
					end
				end
				IDX_WIN_HIGH:
					nxt_st.lim_hi = pwdata[WIN_ADR_MSB:WIN_ADR_LSB];
				default: ;
			endcase
		end
		nxt_st.fwd = io_valid && win.hit;
		if (!resetn)
		begin
			nxt_st         = '0;
			nxt_st.up_bus  = RST_BUS_NUM;
			nxt_st.dn_bus  = RST_BUS_NUM;
			nxt_st.hi_bus  = RST_BUS_NUM;
			nxt_st.base_hi = RST_WIN_LOW;
			nxt_st.lim_hi  = RST_WIN_HIGH;
			nxt_st.cap     = RST_CAP;
			nxt_st.prdata  = RO_ZERO;
		end
	end

	always_ff @(posedge clk)
	begin
		st_ff <= nxt_st;
	end

	assign pready     = st_ff.pready;
	assign prdata     = st_ff.prdata;
	assign pslverr    = st_ff.pslverr;
	assign io_forward = st_ff.fwd;

	// Qualified strobes for the assertions below
	logic rd_now;
	logic cap_wr;
	logic low_wr;
	logic high_wr;

	assign rd_now  = psel && penable && pready && !pwrite && !pslverr;
	assign cap_wr  = wr_done && acc_idx == IDX_WIN_LOW && cap_unlock;
	assign low_wr  = wr_done && acc_idx == IDX_WIN_LOW;
	assign high_wr = wr_done && acc_idx == IDX_WIN_HIGH;

	chk_self_test_zero: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_SELF_TEST
		|-> prdata == RO_ZERO)
		else $error("self-test byte not zero");

	chk_base_addr_zero: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && (acc_idx == IDX_BASE_ZERO || acc_idx == IDX_BASE_ONE)
		|-> prdata == RO_ZERO)
		else $error("base address register not zero");

	chk_up_bus_write: assert property
		(@(posedge clk) disable iff (!resetn)
		wr_done && acc_idx == IDX_UP_BUS
		|=> st_ff.up_bus == $past(pwdata[7:0]))
		else $error("upstream bus number not written");

	chk_up_bus_readback: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_UP_BUS
		|-> prdata == {24'h0, st_ff.up_bus})
		else $error("upstream bus number readback wrong");

	chk_up_bus_inert: assert property
		(@(posedge clk) disable iff (!resetn)
		wr_done && acc_idx == IDX_UP_BUS
		|=> $stable(st_ff.base_hi) && $stable(st_ff.lim_hi) &&
		$stable(st_ff.cap))
		else $error("upstream bus write disturbed window");

	chk_dn_bus_write: assert property
		(@(posedge clk) disable iff (!resetn)
		wr_done && acc_idx == IDX_DN_BUS
		|=> st_ff.dn_bus == $past(pwdata[7:0]))
		else $error("downstream bus number not written");

	chk_dn_bus_readback: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_DN_BUS
		|-> prdata == {24'h0, st_ff.dn_bus})
		else $error("downstream bus number readback wrong");

	chk_hi_bus_write: assert property
		(@(posedge clk) disable iff (!resetn)
		wr_done && acc_idx == IDX_HI_BUS
		|=> st_ff.hi_bus == $past(pwdata[7:0]))
		else $error("highest bus number not written");

	chk_hi_bus_readback: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_HI_BUS
		|-> prdata == {24'h0, st_ff.hi_bus})
		else $error("highest bus number readback wrong");

	chk_bus_reset: assert property
		(@(posedge clk)
		!resetn
		|=> st_ff.up_bus == RST_BUS_NUM && st_ff.dn_bus == RST_BUS_NUM &&
		st_ff.hi_bus == RST_BUS_NUM)
		else $error("bus number reset values wrong");

	chk_lat_timer_zero: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_LAT_TIMER
		|-> prdata == RO_ZERO)
		else $error("latency timer not zero");

	chk_ro_no_store: assert property
		(@(posedge clk) disable iff (!resetn)
		wr_done && (acc_idx == IDX_SELF_TEST || acc_idx == IDX_BASE_ZERO ||
		acc_idx == IDX_BASE_ONE || acc_idx == IDX_LAT_TIMER)
		|=> $stable(st_ff.up_bus) && $stable(st_ff.dn_bus) &&
		$stable(st_ff.hi_bus) && $stable(st_ff.base_hi) &&
		$stable(st_ff.lim_hi) && $stable(st_ff.cap))
		else $error("write to read-only register stored data");

	chk_cap_locked: assert property
		(@(posedge clk) disable iff (!resetn)
		low_wr && !cap_unlock
		|=> $stable(st_ff.cap))
		else $error("capability changed while locked");

	chk_cap_unlocked: assert property
		(@(posedge clk) disable iff (!resetn)
		cap_wr
		|=> st_ff.cap == $past(pwdata[WIN_CAP_BIT]))
		else $error("capability not written while unlocked");

	chk_cap_write_only: assert property
		(@(posedge clk) disable iff (!resetn)
		$changed(st_ff.cap)
		|-> $past(cap_wr) || !$past(resetn))
		else $error("capability changed without unlocked write");

	chk_cap_mirror: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_WIN_HIGH
		|-> prdata[0] == st_ff.cap && prdata[3:1] == 3'h0)
		else $error("window high bit 0 not mirroring");

	chk_win_low_write: assert property
		(@(posedge clk) disable iff (!resetn)
		low_wr
		|=> st_ff.base_hi == $past(pwdata[WIN_ADR_MSB:WIN_ADR_LSB]))
		else $error("window low bound not written");

	chk_win_low_read: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_WIN_LOW
		|-> prdata[7:4] == st_ff.base_hi && prdata[3:1] == 3'h0 &&
		prdata[0] == st_ff.cap && prdata[31:8] == 24'h0)
		else $error("window low readback wrong");

	chk_base_write_only: assert property
		(@(posedge clk) disable iff (!resetn)
		$changed(st_ff.base_hi)
		|-> $past(low_wr) || !$past(resetn))
		else $error("window low bound changed without write");

	chk_win_high_write: assert property
		(@(posedge clk) disable iff (!resetn)
		high_wr
		|=> st_ff.lim_hi == $past(pwdata[WIN_ADR_MSB:WIN_ADR_LSB]))
		else $error("window high bound not written");

	chk_win_high_read: assert property
		(@(posedge clk) disable iff (!resetn)
		rd_now && acc_idx == IDX_WIN_HIGH
		|-> prdata[7:4] == st_ff.lim_hi && prdata[31:8] == 24'h0)
		else $error("window high readback wrong");

	chk_limit_write_only: assert property
		(@(posedge clk) disable iff (!resetn)
		$changed(st_ff.lim_hi)
		|-> $past(high_wr) || !$past(resetn))
		else $error("window high bound changed without write");

	chk_win_reset: assert property
		(@(posedge clk)
		!resetn
		|=> st_ff.base_hi == RST_WIN_LOW && st_ff.lim_hi == RST_WIN_HIGH &&
		st_ff.cap == RST_CAP)
		else $error("window reset values wrong");

	chk_fwd_window: assert property
		(@(posedge clk) disable iff (!resetn)
		1'b1
		|=> io_forward == ($past(io_valid) &&
		$past(io_addr) >= {16'h0, $past(st_ff.base_hi), WIN_LOW_FILL} &&
		$past(io_addr) <= {16'h0, $past(st_ff.lim_hi), WIN_HIGH_FILL}))
		else $error("forward decision wrong");

	chk_fwd_needs_valid: assert property
		(@(posedge clk) disable iff (!resetn)
		!io_valid
		|=> !io_forward)
		else $error("forward without a valid request");

endmodule : bch_regs

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	import bch_pkg::*;
	logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, io_addr = 32'h0, rd;
	logic [3:0]  pstrb = 4'h1;
	logic        pready, pslverr, cap_unlock = 0, io_valid = 0;
	logic        io_forward, er;
	int          err_total = 0, checks_done = 0, cyc = 0;

	bch_regs bch_regs_i (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cap_unlock(cap_unlock), .io_valid(io_valid), .io_addr(io_addr),
		.io_forward(io_forward));

	always #10 clk = ~clk;

	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic chk(input string       nm,
		input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; waits for pready, the bench timeout ends a hang
	task automatic apb(input logic        w,
		input logic [5:0]  i,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input string       nm,
		input logic [5:0]  i,
		input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		chk(nm, e, rd);
		chk("pslverr", 32'h0, {31'h0, er});
	endtask : rd_chk

	task automatic io_chk(input logic v, input logic [31:0] a, input logic e);
		@(posedge clk);
		io_valid <= v;
		io_addr <= a;
		@(posedge clk);
		@(posedge clk);
		chk("io_forward", {31'h0, e}, {31'h0, io_forward});
		io_valid <= 1'b0;
	endtask : io_chk

	task automatic t_reset_and_ro;
		rd_chk("self_test", IDX_SELF_TEST, 32'h0);
		rd_chk("base0", IDX_BASE_ZERO, 32'h0);
		rd_chk("base1", IDX_BASE_ONE, 32'h0);
		rd_chk("upstream", IDX_UP_BUS, 32'h0);
		rd_chk("downstream", IDX_DN_BUS, 32'h0);
		rd_chk("highest", IDX_HI_BUS, 32'h0);
		rd_chk("latency", IDX_LAT_TIMER, 32'h0);
		rd_chk("win_low", IDX_WIN_LOW, 32'hf1);
		rd_chk("win_high", IDX_WIN_HIGH, 32'h01);
		apb(1'b1, IDX_SELF_TEST, 32'hffff_ffff);
		apb(1'b1, IDX_BASE_ZERO, 32'hffff_ffff);
		apb(1'b1, IDX_LAT_TIMER, 32'hffff_ffff);
		rd_chk("self_test wr", IDX_SELF_TEST, 32'h0);
		rd_chk("base0 wr", IDX_BASE_ZERO, 32'h0);
		rd_chk("latency wr", IDX_LAT_TIMER, 32'h0);
	endtask : t_reset_and_ro

	task automatic t_bus_numbers;
		apb(1'b1, IDX_UP_BUS, 32'h5a);
		apb(1'b1, IDX_DN_BUS, 32'ha5);
		apb(1'b1, IDX_HI_BUS, 32'hff);
		rd_chk("upstream", IDX_UP_BUS, 32'h5a);
		rd_chk("downstream", IDX_DN_BUS, 32'ha5);
		rd_chk("highest", IDX_HI_BUS, 32'hff);
	endtask : t_bus_numbers

	task automatic t_capability;
		apb(1'b1, IDX_WIN_LOW, 32'h2e);
		rd_chk("locked low", IDX_WIN_LOW, 32'h21);
		cap_unlock <= 1'b1;
		apb(1'b1, IDX_WIN_LOW, 32'h20);
		rd_chk("unlocked low", IDX_WIN_LOW, 32'h20);
		apb(1'b1, IDX_WIN_HIGH, 32'h3f);
		rd_chk("mirror high", IDX_WIN_HIGH, 32'h30);
		apb(1'b1, IDX_WIN_LOW, 32'h21);
		cap_unlock <= 1'b0;
		rd_chk("mirror back", IDX_WIN_HIGH, 32'h31);
	endtask : t_capability

	task automatic t_window;
		apb(1'b1, IDX_WIN_LOW, 32'h10);
		apb(1'b1, IDX_WIN_HIGH, 32'h20);
		io_chk(1'b1, 32'h0000_0fff, 1'b0);
		io_chk(1'b1, 32'h0000_1000, 1'b1);
		io_chk(1'b1, 32'h0000_2fff, 1'b1);
		io_chk(1'b1, 32'h0000_3000, 1'b0);
		io_chk(1'b0, 32'h0000_1000, 1'b0);
		io_chk(1'b1, 32'h0001_1000, 1'b0);
		apb(1'b1, IDX_UP_BUS, 32'h00);
		io_chk(1'b1, 32'h0000_2000, 1'b1);
	endtask : t_window

	task automatic t_unmapped;
		apb(1'b0, 6'h11, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		pstrb <= 4'h0;
		apb(1'b1, IDX_DN_BUS, 32'h77);
		pstrb <= 4'h1;
		rd_chk("no strobe", IDX_DN_BUS, 32'ha5);
	endtask : t_unmapped

	// A reset in mid-run must restore every stored field
	task automatic t_mid_reset;
		apb(1'b1, IDX_HI_BUS, 32'h3c);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd_chk("highest rst", IDX_HI_BUS, 32'h0);
		rd_chk("upstream rst", IDX_UP_BUS, 32'h0);
		rd_chk("downstream rst", IDX_DN_BUS, 32'h0);
		rd_chk("win_low rst", IDX_WIN_LOW, 32'hf1);
		rd_chk("win_high rst", IDX_WIN_HIGH, 32'h01);
	endtask : t_mid_reset

	initial
	begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_reset_and_ro();
		t_bus_numbers();
		t_capability();
		t_window();
		t_unmapped();
		t_mid_reset();
		report_and_stop();
	end
endmodule : tb
